// ==== src/dfba_ctrl.sv ====
// design: byte access controller for the on-chip data flash
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - one byte per operation, data from low data byte, location from address.
// - each byte write erases the location first, then programs it.
// - write duration comes from an internal timer, not software.
// - byte read command with start puts the byte in data register next cycle.
// - low data byte holds read value until next read or software write.
// - page read aimed at data flash is rejected.
// - write starts only after 0x55 then 0xAA immediately before start.
// - page write aimed at data flash is rejected.
// - hardware never clears the command field.
// - control, address and data registers ignore writes while a write runs.
// - at write end, start bit clears and completion flag sets.
// - page erase on data flash rejected; software writes 0xff instead.
// - code protect blocks external port access; internal works unless write protected.
// - write start on protected or invalid target does nothing and sets error flag.
// - every byte write, with or without increment, needs a fresh unlock.
// - command codes 000..111 decode; only write and write with increment need unlock.
// - error flag set on protected, unimplemented, locked or page op; reset clears it, a reset-aborted write is not flagged.
// - unlock register always reads zero.
module dfba_ctrl #(
    parameter int FLASH_SIZE = dfba_pkg::FLASH_BYTES
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire dfba_pkg::dfba_bus_type sfr,
    input  wire logic                  code_protect_bit,
    input  wire logic                  write_protect,
    input  wire logic                  ext_port_req,
    input  wire logic                  ext_port_wr,
    input  wire logic [21:0]           ext_port_addr,
    input  wire logic [7:0]            ext_port_wdata,
    output var  logic [7:0]            sfr_rdata,
    output var  logic [7:0]            ext_port_rdata,
    output var  logic                  ext_port_denied,
    output var  logic                  busy
);
    import dfba_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        dfba_state_type state;
        dfba_key_type   key;
        logic           go;
        logic           write_error_flag;
        logic           done;
        logic [2:0]     cmd;
        logic [21:0]    addr;
        logic [15:0]    data;
        logic [5:0]     timer;
        logic           was_busy;
        logic [7:0]     rdata;
        logic [7:0]     ext_rdata;
        logic           ext_denied;
        logic           busy;
    } dfba_regs_type;

    dfba_regs_type r;
    dfba_regs_type next_r;
    logic [7:0]    data_flash_array [FLASH_SIZE];
    logic          mem_we;
    logic [8:0]    mem_idx;
    logic [7:0]    mem_wdata;

    function automatic logic in_flash(input logic [21:0] a);
        in_flash = (a >= FLASH_BASE) && (a < FLASH_BASE + 22'(FLASH_SIZE));
    endfunction : in_flash

    function automatic logic [8:0] flash_index(input logic [21:0] a);
        logic [21:0] off;
        off = a - FLASH_BASE;
        flash_index = off[8:0];
    endfunction : flash_index

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic writing;
        logic start;
        writing = (r.state != DFBA_IDLE);
        start   = 1'b0;
        next_r  = r;
        mem_we    = 1'b0;
        mem_idx   = flash_index(r.addr);
        mem_wdata = r.data[7:0];
        next_r.ext_denied = 1'b0;
        if (sfr.wr && !writing) begin
            unique case (sfr.addr)
                OFS_OP_CTRL:   start = sfr.wdata[BIT_GO];
                OFS_CMD_CTRL: begin
                    next_r.cmd = sfr.wdata[2:0];
                    if (!sfr.wdata[BIT_WR_ERROR]) next_r.write_error_flag = 1'b0;
                end
                OFS_ADDR_LOW:  next_r.addr[7:0]   = sfr.wdata;
                OFS_ADDR_HIGH: next_r.addr[15:8]  = sfr.wdata;
                OFS_ADDR_UPP:  next_r.addr[21:16] = sfr.wdata[5:0];
                OFS_DATA_LOW:  next_r.data[7:0]   = sfr.wdata;
                OFS_DATA_HIGH: next_r.data[15:8]  = sfr.wdata;
                default: ;
            endcase
        end
        // the done flag is clear-on-write-zero and may be cleared even mid-write
        if (sfr.wr && sfr.addr == OFS_FLAGS && !sfr.wdata[BIT_DONE]) next_r.done = 1'b0;
        // key tracker: any other bus write between the keys and start breaks the chain
        if (sfr.wr && !writing) begin
            if (sfr.addr == OFS_UNLOCK)
                next_r.key = (sfr.wdata == KEY_FIRST) ? DFBA_KEY1 :
                             (sfr.wdata == KEY_SECOND && r.key == DFBA_KEY1) ?
                             DFBA_ARMED : DFBA_LOCKED;
            else
                next_r.key = DFBA_LOCKED;
        end
        if (start) begin
            unique case (dfba_cmd_type'(r.cmd))
                DFBA_CMD_READ, DFBA_CMD_READ_INC: begin
                    if (in_flash(r.addr))
                        next_r.data[7:0] = data_flash_array[mem_idx];
                    if (r.cmd == DFBA_CMD_READ_INC) next_r.addr = r.addr + 22'h1;
                    next_r.done = 1'b1;
                end
                DFBA_CMD_WRITE, DFBA_CMD_WR_INC: begin
                    if (r.key != DFBA_ARMED || write_protect || !in_flash(r.addr))
                        next_r.write_error_flag = 1'b1;
                    else begin
                        next_r.go    = 1'b1;
                        next_r.state = DFBA_ERASE;
                        next_r.timer = 6'(ERASE_CYCLES - 1);
                    end
                end
                DFBA_CMD_RD_PAGE, DFBA_CMD_WR_PAGE, DFBA_CMD_ER_PAGE:
                    if (in_flash(r.addr))
                        next_r.write_error_flag = 1'b1;
                DFBA_CMD_NOP: ;
            endcase
        end
        // ----------------------------------------------------------------
        // self-timed write: erase to all ones, then program
        // ----------------------------------------------------------------
        unique case (r.state)
            DFBA_IDLE: ;
            DFBA_ERASE: begin
                if (r.timer == 6'h0) begin
                    mem_we       = 1'b1;
                    mem_wdata    = ERASED_BYTE;
                    next_r.state = DFBA_PROG;
                    next_r.timer = 6'(PROG_CYCLES - 1);
                end else next_r.timer = r.timer - 6'h1;
            end
            DFBA_PROG: begin
                if (r.timer == 6'h0) begin
                    mem_we       = 1'b1;
                    next_r.state = DFBA_IDLE;
                    next_r.go    = 1'b0;
                    next_r.done  = 1'b1;
                    if (r.cmd == DFBA_CMD_WR_INC) next_r.addr = r.addr + 22'h1;
                end else next_r.timer = r.timer - 6'h1;
            end
        endcase
        next_r.was_busy = (next_r.state != DFBA_IDLE);
        next_r.busy     = next_r.was_busy;
        // external port: code protect blocks it, and it never races a write
        if (ext_port_req) begin
            if (code_protect_bit || writing) next_r.ext_denied = 1'b1;
            else if (in_flash(ext_port_addr) && !ext_port_wr)
                next_r.ext_rdata = data_flash_array[flash_index(ext_port_addr)];
        end
        // read mux; command field is returned as held, hardware never edits it
        unique case (sfr.addr)
            OFS_OP_CTRL:   next_r.rdata = {7'h00, next_r.go};
            OFS_CMD_CTRL:  next_r.rdata = {next_r.write_error_flag, 4'h0, next_r.cmd};
            OFS_UNLOCK:    next_r.rdata = 8'h00;
            OFS_ADDR_LOW:  next_r.rdata = next_r.addr[7:0];
            OFS_ADDR_HIGH: next_r.rdata = next_r.addr[15:8];
            OFS_ADDR_UPP:  next_r.rdata = {2'h0, next_r.addr[21:16]};
            OFS_DATA_LOW:  next_r.rdata = next_r.data[7:0];
            OFS_DATA_HIGH: next_r.rdata = next_r.data[15:8];
            OFS_FLAGS:     next_r.rdata = {7'h00, next_r.done};
            default:       next_r.rdata = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // registers and array
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            r       <= '0;
            r.state <= DFBA_IDLE;
            r.key   <= DFBA_LOCKED;
            r.addr  <= ADDR_RESET;
            r.data  <= DATA_RESET;
        end else begin
            r <= next_r;
        end
    end

    // no reset on the cells: they are nonvolatile; a write cut by rst is not flagged
    always_ff @(posedge core_clk) begin
        if (mem_we) data_flash_array[mem_idx] <= mem_wdata;
        if (ext_port_req && !code_protect_bit && !busy && ext_port_wr
            && in_flash(ext_port_addr))
            data_flash_array[flash_index(ext_port_addr)] <= ext_port_wdata;
    end

    assign sfr_rdata       = r.rdata;
    assign ext_port_rdata  = r.ext_rdata;
    assign ext_port_denied = r.ext_denied;
    assign busy            = r.busy;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_write_locked: assert property (@(posedge core_clk) disable iff (rst)
        (sfr.wr && sfr.addr == OFS_OP_CTRL && sfr.wdata[0] && r.state == DFBA_IDLE
         && r.cmd == 3'h3 && r.key != DFBA_ARMED)
        |=> (r.write_error_flag && r.state == DFBA_IDLE))
        else $error("locked write was not refused");
    a_write_timed: assert property (@(posedge core_clk) disable iff (rst)
        $rose(r.state == DFBA_ERASE) |-> ##50 (r.state == DFBA_PROG) ##50 (r.state == DFBA_IDLE))
        else $error("write cycle length wrong");
    a_write_end: assert property (@(posedge core_clk) disable iff (rst)
        (r.state == DFBA_PROG && r.timer == 6'h0) |=> (!r.go && r.done))
        else $error("write end did not clear go and set done");
    a_hold_busy: assert property (@(posedge core_clk) disable iff (rst)
        (r.state != DFBA_IDLE && sfr.wr) |=> $stable(r.addr) || r.state == DFBA_IDLE)
        else $error("address changed during write");
    a_cmd_kept: assert property (@(posedge core_clk) disable iff (rst)
        !(sfr.wr && sfr.addr == OFS_CMD_CTRL) |=> $stable(r.cmd))
        else $error("command field changed by hardware");
    a_unlock_zero: assert property (@(posedge core_clk) disable iff (rst)
        (sfr.addr == OFS_UNLOCK) |=> (sfr_rdata == 8'h00))
        else $error("unlock register read not zero");
    a_page_refused: assert property (@(posedge core_clk) disable iff (rst)
        (sfr.wr && sfr.addr == OFS_OP_CTRL && sfr.wdata[0] && r.state == DFBA_IDLE
         && r.cmd == 3'h6 && in_flash(r.addr))
        |=> (r.write_error_flag && r.state == DFBA_IDLE))
        else $error("page erase on data flash accepted");
    a_nop_quiet: assert property (@(posedge core_clk) disable iff (rst)
        (sfr.wr && sfr.addr == OFS_OP_CTRL && sfr.wdata[0] && r.state == DFBA_IDLE
         && r.cmd == 3'h7) |=> ($stable(r.write_error_flag) && !r.go && r.state == DFBA_IDLE))
        else $error("reserved command had an effect");
    a_ext_block: assert property (@(posedge core_clk) disable iff (rst)
        (ext_port_req && code_protect_bit) |=> ext_port_denied)
        else $error("external access not blocked");
endmodule : dfba_ctrl
`default_nettype wire

// ==== src/dfba_pkg.sv ====
// package: register map, field layout and timing constants of the data flash access block
package dfba_pkg;
    // ----------------------------------------------------------------
    // register offsets (special function register space)
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_OP_CTRL   = 12'h040;
    localparam logic [11:0] OFS_CMD_CTRL  = 12'h041;
    localparam logic [11:0] OFS_UNLOCK    = 12'h042;
    localparam logic [11:0] OFS_ADDR_LOW  = 12'h043;
    localparam logic [11:0] OFS_ADDR_HIGH = 12'h044;
    localparam logic [11:0] OFS_ADDR_UPP  = 12'h045;
    localparam logic [11:0] OFS_DATA_LOW  = 12'h046;
    localparam logic [11:0] OFS_DATA_HIGH = 12'h047;
    localparam logic [11:0] OFS_FLAGS     = 12'h048;
    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int         BIT_GO       = 0;
    localparam int         BIT_WR_ERROR = 7;
    localparam int         BIT_DONE     = 0;
    localparam logic [7:0] KEY_FIRST    = 8'h55;
    localparam logic [7:0] KEY_SECOND   = 8'haa;
    localparam logic [7:0] ERASED_BYTE  = 8'hff;
    localparam logic [21:0] ADDR_RESET  = 22'h000000;
    localparam logic [15:0] DATA_RESET  = 16'h0000;
    // ----------------------------------------------------------------
    // data flash placement and timing
    // ----------------------------------------------------------------
    localparam logic [21:0] FLASH_BASE   = 22'h380000;
    localparam int          FLASH_BYTES  = 512;
    localparam int          CLK_MHZ      = 25;
    localparam int          ERASE_US     = 2;
    localparam int          PROG_US      = 2;
    localparam int          ERASE_CYCLES = ERASE_US * CLK_MHZ;
    localparam int          PROG_CYCLES  = PROG_US * CLK_MHZ;
    // ----------------------------------------------------------------
    // commands and states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        DFBA_CMD_READ     = 3'h0,
        DFBA_CMD_READ_INC = 3'h1,
        DFBA_CMD_RD_PAGE  = 3'h2,
        DFBA_CMD_WRITE    = 3'h3,
        DFBA_CMD_WR_INC   = 3'h4,
        DFBA_CMD_WR_PAGE  = 3'h5,
        DFBA_CMD_ER_PAGE  = 3'h6,
        DFBA_CMD_NOP      = 3'h7
    } dfba_cmd_type;
    typedef enum logic [2:0] {
        DFBA_IDLE  = 3'b001,
        DFBA_ERASE = 3'b010,
        DFBA_PROG  = 3'b100
    } dfba_state_type;
    typedef enum logic [1:0] {
        DFBA_LOCKED = 2'h0,
        DFBA_KEY1   = 2'h1,
        DFBA_ARMED  = 2'h2
    } dfba_key_type;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } dfba_bus_type;
endpackage : dfba_pkg

// ==== test/dfba_cpu_model.sv ====
// partner model: cpu software that reaches the data flash block through its registers
`timescale 1ns/1ps
`default_nettype none
module dfba_cpu_model (
    input  wire logic                   core_clk,
    input  wire logic [7:0]             sfr_rdata,
    output var  dfba_pkg::dfba_bus_type sfr
);
    import dfba_pkg::*;
    // ----------------------------------------------------------------
    // bus cycles: called just after a rising edge, return just after one
    // ----------------------------------------------------------------
    initial begin
        sfr = '{wr: 1'b0, rd: 1'b0, addr: 12'h000, wdata: 8'h00};
    end
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        #1;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~sfr.wdata};
        @(posedge core_clk);
        #1;
        d = sfr_rdata;
    endtask : rd
    // released lines flip so a stale value never passes for a live one
    task automatic idle();
        sfr = '{wr: 1'b0, rd: 1'b0, addr: ~sfr.addr, wdata: ~sfr.wdata};
        @(posedge core_clk);
        #1;
    endtask : idle
    // ----------------------------------------------------------------
    // software sequences
    // ----------------------------------------------------------------
    task automatic set_addr(input logic [21:0] a);
        wr(OFS_ADDR_LOW, a[7:0]);
        wr(OFS_ADDR_HIGH, a[15:8]);
        wr(OFS_ADDR_UPP, {2'b00, a[21:16]});
    endtask : set_addr
    // key: 0 none, 1 proper pair, 2 pair split by another write
    task automatic launch(input logic [2:0] cmd, input int key);
        wr(OFS_CMD_CTRL, {5'h00, cmd});
        if (key != 0) begin
            wr(OFS_UNLOCK, KEY_FIRST);
            if (key == 2) begin
                wr(OFS_ADDR_LOW, 8'h00);
            end
            wr(OFS_UNLOCK, KEY_SECOND);
        end
        wr(OFS_OP_CTRL, 8'h01);
    endtask : launch
    task automatic clear_done();
        wr(OFS_FLAGS, 8'h00);
    endtask : clear_done
endmodule : dfba_cpu_model
`default_nettype wire

// ==== test/tb_data_flash_byte_access.sv ====
// testbench: data flash byte access block driven by a cpu software model
`timescale 1ns/1ps
`default_nettype none
module tb_data_flash_byte_access;
    import dfba_pkg::*;
    logic         core_clk, rst, code_protect_bit, write_protect;
    logic         ext_port_req, ext_port_wr, ext_port_denied, busy;
    logic [21:0]  ext_port_addr, a;
    logic [7:0]   ext_port_wdata, ext_port_rdata, sfr_rdata, d, v;
    logic [2:0]   cmd;
    dfba_bus_type sfr;
    int           fails, checks, cycles, n;
    // ----------------------------------------------------------------
    // harness
    // ----------------------------------------------------------------
    dfba_ctrl #(.FLASH_SIZE(FLASH_BYTES)) dut_u (.core_clk(core_clk), .rst(rst), .sfr(sfr),
        .code_protect_bit(code_protect_bit), .write_protect(write_protect),
        .ext_port_req(ext_port_req), .ext_port_wr(ext_port_wr), .ext_port_addr(ext_port_addr),
        .ext_port_wdata(ext_port_wdata), .sfr_rdata(sfr_rdata), .ext_port_rdata(ext_port_rdata),
        .ext_port_denied(ext_port_denied), .busy(busy));
    dfba_cpu_model cpu_u (.core_clk(core_clk), .sfr_rdata(sfr_rdata), .sfr(sfr));
    always #20 core_clk = ~core_clk;
    // whole run is a few hundred cycles, so this only trips on a hang
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic ext_read(input logic [21:0] addr);
        ext_port_addr = addr;
        ext_port_req = 1'b1;
        @(posedge core_clk);
        #1;
        ext_port_req = 1'b0;
        ext_port_addr = ~addr;
    endtask : ext_read
    task automatic report_and_stop();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        {code_protect_bit, write_protect, ext_port_req, ext_port_wr} = 4'h0;
        ext_port_addr = 22'h000000;
        ext_port_wdata = 8'h00;
        void'($urandom(53227));
        repeat (8) @(posedge core_clk);
        #1;
        rst = 1'b0;
        for (int i = 0; i < 9; i++) begin
            cpu_u.rd(OFS_OP_CTRL + 12'(i), v);
            check("reset value", v, 8'h00);
        end
        cpu_u.wr(OFS_UNLOCK, KEY_FIRST);
        cpu_u.rd(OFS_UNLOCK, v);
        check("unlock readback", v, 8'h00);
        // first pass erases by writing all ones, second writes a random byte
        for (int i = 0; i < 2; i++) begin
            a = FLASH_BASE + 22'($urandom_range(FLASH_BYTES - 1));
            cpu_u.clear_done();
            d = (i == 0) ? ERASED_BYTE : 8'($urandom);
            cpu_u.set_addr(a);
            cpu_u.wr(OFS_DATA_LOW, d);
            cpu_u.launch(DFBA_CMD_WRITE, 1);
            cpu_u.wr(OFS_DATA_LOW, ~d);
            cpu_u.idle();
            n = 2;
            while (busy === 1'b1 && n < 1000) begin
                @(posedge core_clk);
                #1;
                n++;
            end
            check("write cycles", 8'(n), 8'(ERASE_CYCLES + PROG_CYCLES));
            cpu_u.rd(OFS_OP_CTRL, v);
            check("go after write", v, 8'h00);
            cpu_u.rd(OFS_FLAGS, v);
            check("done flag", v & 8'h01, 8'h01);
            cpu_u.rd(OFS_CMD_CTRL, v);
            check("command kept", v, 8'h03);
            cpu_u.rd(OFS_DATA_LOW, v);
            check("data held in write", v, d);
            cpu_u.clear_done();
            cpu_u.rd(OFS_FLAGS, v);
            check("done cleared", v & 8'h01, 8'h00);
            cpu_u.wr(OFS_DATA_LOW, ~d);
            cpu_u.launch(DFBA_CMD_READ, 0);
            cpu_u.rd(OFS_DATA_LOW, v);
            check("read back", v, d);
        end
        ext_read(a);
        check("port read", ext_port_rdata, d);
        check("port allowed", {7'h00, ext_port_denied}, 8'h00);
        ext_port_wr = 1'b1;
        ext_port_wdata = ~d;
        ext_read(a);
        ext_port_wr = 1'b0;
        ext_read(a);
        check("port write", ext_port_rdata, ~d);
        ext_port_wr = 1'b1;
        ext_port_wdata = d;
        ext_read(a);
        ext_port_wr = 1'b0;
        // refused starts: no key, split key, protected, bad address, page ops, reserved
        cpu_u.wr(OFS_DATA_LOW, ~d);
        for (int k = 0; k < 7; k++) begin
            cmd = (k == 4) ? 3'h5 : (k == 5) ? 3'h6 : (k == 6) ? 3'h7 : 3'h3;
            write_protect = (k == 2);
            cpu_u.set_addr((k == 3) ? FLASH_BASE + 22'(FLASH_BYTES) : a);
            cpu_u.launch(cmd, (k == 0 || k == 6) ? 0 : (k == 1) ? 2 : 1);
            cpu_u.rd(OFS_OP_CTRL, v);
            check("go refused", v, 8'h00);
            cpu_u.rd(OFS_CMD_CTRL, v);
            check("error flag", v, {k != 6, 4'h0, cmd});
        end
        write_protect = 1'b0;
        cpu_u.launch(DFBA_CMD_RD_PAGE, 0);
        cpu_u.rd(OFS_DATA_LOW, v);
        check("page read ignored", v, ~d);
        cpu_u.launch(DFBA_CMD_READ_INC, 0);
        cpu_u.rd(OFS_DATA_LOW, v);
        check("memory unchanged", v, d);
        cpu_u.rd(OFS_ADDR_LOW, v);
        check("post increment", v, 8'(a + 22'h1));
        code_protect_bit = 1'b1;
        ext_port_wr = 1'b1;
        ext_port_wdata = ~d;
        ext_read(a);
        ext_port_wr = 1'b0;
        check("port denied", {7'h00, ext_port_denied}, 8'h01);
        cpu_u.set_addr(a);
        cpu_u.wr(OFS_DATA_LOW, ~d);
        cpu_u.launch(DFBA_CMD_READ, 0);
        cpu_u.rd(OFS_DATA_LOW, v);
        check("internal read", v, d);
        // internal write with post increment still runs under code protect
        cpu_u.set_addr(a);
        cpu_u.wr(OFS_DATA_LOW, ~d);
        cpu_u.launch(DFBA_CMD_WR_INC, 1);
        cpu_u.wr(OFS_DATA_LOW, d);
        cpu_u.idle();
        n = 2;
        while (busy === 1'b1 && n < 1000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check("protected write cycles", 8'(n), 8'(ERASE_CYCLES + PROG_CYCLES));
        cpu_u.rd(OFS_DATA_LOW, v);
        check("data held in inc write", v, ~d);
        cpu_u.rd(OFS_ADDR_LOW, v);
        check("write post increment", v, 8'(a + 22'h1));
        cpu_u.set_addr(a);
        cpu_u.wr(OFS_DATA_LOW, d);
        cpu_u.launch(DFBA_CMD_READ, 0);
        cpu_u.rd(OFS_DATA_LOW, v);
        check("internal write", v, ~d);
        cpu_u.wr(OFS_CMD_CTRL, 8'h00);
        report_and_stop();
    end
endmodule : tb_data_flash_byte_access
`default_nettype wire
